// ==== smsu_pkg.sv ====
/*
 * Package for the serial shift unit: register map, field layout,
 * reset values and the master clock prescaler table.
 * Assumes nothing of its surroundings; every user writes smsu_pkg::name.
 */
`default_nettype none

package smsu_pkg;

    // ----------------
    // Register byte addresses (one aligned 32-bit word each)
    // ----------------
    localparam logic [3:0] CTRL_OFS   = 4'h0;  // Control
    localparam logic [3:0] STATUS_OFS = 4'h4;  // Flags
    localparam logic [3:0] DATA_OFS   = 4'h8;  // Data port
    localparam logic [3:0] PINDIR_OFS = 4'hc;  // Port direction

    // ----------------
    // Control fields
    // ----------------
    localparam int CTRL_ENABLE_BIT = 0;  // Block enable
    localparam int CTRL_MASTER_BIT = 1;  // Master select
    localparam int CTRL_LSBF_BIT   = 2;  // LSB first
    localparam int CTRL_DBL_BIT    = 3;  // Double speed select
    localparam int CTRL_BUF_BIT    = 4;  // Buffer mode enable
    localparam int CTRL_SSD_BIT    = 5;  // Select pin disable
    localparam int CTRL_PRESC_LSB  = 8;  // Prescaler, 3 bits
    localparam int CTRL_W          = 11; // Stored width
    localparam logic [10:0] CTRL_RESET = 11'h000;

    // ----------------
    // Status fields (done and collision flags write one to clear)
    // ----------------
    localparam int STAT_DONE_BIT = 0;  // Transfer or mode-loss event
    localparam int STAT_WCOL_BIT = 1;  // Write collision flag
    localparam int STAT_BUSY_BIT = 2;  // Read only: shifting
    localparam int STAT_TXE_BIT  = 3;  // Read only: tx buffer empty

    // ----------------
    // Port direction fields: one per pin, 1 = output
    // ----------------
    localparam int DIR_MOSI_BIT = 0;
    localparam int DIR_MISO_BIT = 1;
    localparam int DIR_SCK_BIT  = 2;
    localparam int DIR_SEL_BIT  = 3;
    localparam logic [3:0] DIR_RESET = 4'h0;

    // ----------------
    // Geometry and timing
    // ----------------
    localparam int BITS_PER_BYTE = 8;
    localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

    // Half-period of the serial clock, in core cycles, per prescaler code.
    // Seven codes are rates; code 7 repeats the slowest one.
    function automatic logic [7:0] half_period(input logic [2:0] presc,
                                               input logic       dbl);
        logic [7:0] h;
        h = 8'h01;
        unique case (presc)
            3'h0: h = 8'h02;
            3'h1: h = 8'h04;
            3'h2: h = 8'h08;
            3'h3: h = 8'h10;
            3'h4: h = 8'h20;
            3'h5: h = 8'h40;
            3'h6: h = 8'h80;
            3'h7: h = 8'h80;
        endcase
        // Double speed: SCK is core clock / 2
        if (dbl) begin
            h = 8'h01;
        end
        return h;
    endfunction

endpackage

`default_nettype wire

// ==== smsu_rate_gen.sv ====
/*
 * Master serial clock rate generator: one-cycle pulse at each SCK
 * half-period boundary while running.
 * Assumes a single core clock and a synchronous run request.
 */
`timescale 1ns/1ns
`default_nettype none

module smsu_rate_gen (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       run,     // Count while high
    input  wire logic       hold,    // Freeze the count while high
    input  wire logic [2:0] presc,   // Rate code
    input  wire logic       dbl,     // Double speed
    output logic            tick     // Half-period pulse
);

    // ----------------
    // Divider
    // ----------------
    logic [7:0] cnt_q;  // Cycles into the half-period
    logic [7:0] lim;    // Half-period length

    assign lim  = smsu_pkg::half_period(presc, dbl);
    assign tick = run && !hold && (cnt_q == lim - 8'h01);

    // Restart from zero so the first edge comes one full half-period late
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 8'h00;
        end else if (!run || tick) begin
            cnt_q <= 8'h00;
        end else if (!hold) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule

`default_nettype wire

// ==== smsu_edge_sync.sv ====
/*
 * Two-flop synchroniser with edge detect for the slave serial clock
 * and select inputs.
 * Assumes the inputs may change at any time relative to core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module smsu_edge_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic din,       // Raw pin level
    input  wire logic init,      // Level assumed before the first sample
    output logic      level,     // Synchronised level
    output logic      rise,      // One-cycle rising pulse
    output logic      fall       // One-cycle falling pulse
);

    // ----------------
    // Sampling stages
    // ----------------
    logic s1_q;  // Metastable stage, read only by s2_q
    logic s2_q;  // Stable level
    logic s3_q;  // Previous stable level
    logic primed_q;

    // Reset constant; init level taken by the clock after release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            s3_q     <= 1'b1;
            primed_q <= 1'b0;
        end else if (!primed_q) begin
            s1_q     <= init;
            s2_q     <= init;
            s3_q     <= init;
            primed_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level = s2_q;
    assign rise  = s2_q && !s3_q;
    assign fall  = !s2_q && s3_q;

endmodule

`default_nettype wire

// ==== smsu_top.sv ====
/*
 * Master/slave serial shift unit with an Avalon-MM register slave.
 * Assumes one 250 MHz core clock, an external pin mux taking the
 * three-signal pin ports, and a debug halt input from the core.
 */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module smsu_top (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        dbg_halt,     // Core halted by debugger
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Pins: input, output, output enable
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        sel_n_i,
    output logic             sel_n_o,
    output logic             sel_n_oe,
    output logic             irq          // Done flag level
);

    // ----------------
    // Declarations
    // ----------------
    typedef enum logic [1:0] {
        SMSU_IDLE  = 2'b00,
        SMSU_SHIFT = 2'b01,
        SMSU_LAST  = 2'b11   // Final bit before completion
    } smsu_state_e;

    smsu_state_e state_q;
    logic [10:0] ctrl_q;       // Control register
    logic [3:0]  dir_q;        // Port direction register
    logic [7:0]  shift_q;      // The one shift register
    logic [7:0]  txbuf_q;      // Transmit buffer
    logic        txfull_q;     // Transmit buffer holds a byte
    logic [7:0]  rx1_q;        // First receive buffer
    logic [7:0]  rx2_q;        // Second receive buffer
    logic        rx2_ok_q;     // Second buffer has data
    logic [2:0]  bitcnt_q;     // Bits done in this byte
    logic        sck_q;        // Master SCK level
    logic        sampled_q;    // Incoming bit caught on leading edge
    logic        done_q;       // Done flag
    logic        wcol_q;       // Write collision flag
    logic        ack_q;        // Bus answer stage

    logic enable, master, lsbf, buffer_mode_enable, select_pin_disable;
    logic run;                 // Enabled and not halted by debugger
    logic tick;                // Master half-period pulse
    logic s_lvl, s_rise;
    logic c_rise, c_fall;
    logic [7:0] shift_nx;      // Shifter after a trailing edge
    logic lead, trail;         // Leading and trailing shift edges
    logic in_bit, out_bit;
    logic busy, finish, start;
    logic wr_ev, rd_ev, data_wr, data_rd, ctrl_wr, stat_wr, dir_wr;
    logic mode_loss;

    assign enable = ctrl_q[smsu_pkg::CTRL_ENABLE_BIT];
    assign master = ctrl_q[smsu_pkg::CTRL_MASTER_BIT];
    assign lsbf   = ctrl_q[smsu_pkg::CTRL_LSBF_BIT];
    assign buffer_mode_enable  = ctrl_q[smsu_pkg::CTRL_BUF_BIT];
    assign select_pin_disable    = ctrl_q[smsu_pkg::CTRL_SSD_BIT];
    assign run    = enable && !dbg_halt;
    assign busy   = (state_q != SMSU_IDLE);

    // ----------------
    // Bus slave: one wait cycle, then the answer
    // ----------------
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_ev   = avs_write && ack_q;
    assign rd_ev   = avs_read && ack_q;
    assign data_wr = wr_ev && avs_address == smsu_pkg::DATA_OFS
                     && avs_byteenable[0];
    assign data_rd = rd_ev && avs_address == smsu_pkg::DATA_OFS;
    assign ctrl_wr = wr_ev && avs_address == smsu_pkg::CTRL_OFS;
    assign stat_wr = wr_ev && avs_address == smsu_pkg::STATUS_OFS
                     && avs_byteenable[0];
    assign dir_wr  = wr_ev && avs_address == smsu_pkg::PINDIR_OFS
                     && avs_byteenable[0];

    // Answer stage: high for exactly one cycle per request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // Read data is registered so it stands at the accepting edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= smsu_pkg::BUS_UNMAPPED;
        end else if (avs_read && !ack_q) begin
            unique case (avs_address)
                smsu_pkg::CTRL_OFS:
                    avs_readdata <= {21'h0, ctrl_q};
                smsu_pkg::STATUS_OFS:
                    avs_readdata <= {28'h0, !txfull_q, busy,
                                     wcol_q, done_q};
                smsu_pkg::DATA_OFS:
                    avs_readdata <= {24'h0, buffer_mode_enable ? rx2_q : rx1_q};
                smsu_pkg::PINDIR_OFS:
                    avs_readdata <= {28'h0, dir_q};
                default:
                    avs_readdata <= smsu_pkg::BUS_UNMAPPED;
            endcase
        end
    end

    // ----------------
    // Control and direction registers
    // ----------------
    // Select low as a master with input select pin loses the bus
    assign mode_loss = run && master && !select_pin_disable
                       && !dir_q[smsu_pkg::DIR_SEL_BIT] && !s_lvl;

    // Hardware clearing of master wins over a software write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= smsu_pkg::CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                if (avs_byteenable[0]) begin
                    ctrl_q[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    ctrl_q[10:8] <= avs_writedata[10:8];
                end
            end
            if (mode_loss) begin
                ctrl_q[smsu_pkg::CTRL_MASTER_BIT] <= 1'b0;
            end
        end
    end

    // Port direction as software sets it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dir_q <= smsu_pkg::DIR_RESET;
        end else if (dir_wr) begin
            dir_q <= avs_writedata[3:0];
        end
    end

    // ----------------
    // Clock sources
    // ----------------
    smsu_rate_gen u_rate (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (enable && master && busy),
        .hold     (dbg_halt),
        .presc    (ctrl_q[smsu_pkg::CTRL_PRESC_LSB +: 3]),
        .dbl      (ctrl_q[smsu_pkg::CTRL_DBL_BIT]),
        .tick     (tick)
    );

    smsu_edge_sync u_sck (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (sck_i),
        .init     (1'b0),
        .level    (),
        .rise     (c_rise),
        .fall     (c_fall)
    );

    smsu_edge_sync u_sel (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (sel_n_i),
        .init     (1'b1),
        .level    (s_lvl),
        .rise     (s_rise),
        .fall     ()
    );

    // Mode 0 timing: sample on rising SCK, shift on falling.
    // Slave edges rely on the master's long enough SCK phases.
    assign lead  = master ? (tick && !sck_q)
                          : (!s_lvl && c_rise);
    assign trail = master ? (tick && sck_q)
                          : (!s_lvl && c_fall);
    assign in_bit  = master ? miso_i : mosi_i;
    assign out_bit = lsbf ? shift_q[0] : shift_q[7];
    assign shift_nx = lsbf ? {sampled_q, shift_q[7:1]}
                           : {shift_q[6:0], sampled_q};
    assign finish  = run && trail && bitcnt_q == 3'h7;
    assign start   = run && master && !busy
                     && (buffer_mode_enable ? txfull_q : data_wr);

    // ----------------
    // Transfer sequencer
    // ----------------
    // Master starts on a data write; slave becomes busy on select low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SMSU_IDLE;
        end else if (!enable || mode_loss || (!master && s_rise)) begin
            state_q <= SMSU_IDLE;
        end else if (run) begin
            unique case (state_q)
                SMSU_IDLE:
                    if (start || (!master && !s_lvl)) begin
                        state_q <= SMSU_SHIFT;
                    end
                SMSU_SHIFT:
                    if (trail && bitcnt_q == 3'h6) begin
                        state_q <= SMSU_LAST;
                    end
                SMSU_LAST:
                    if (finish) begin
                        state_q <= SMSU_IDLE;
                    end
            endcase
        end
    end

    // Master SCK level and bit counter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sck_q    <= 1'b0;
            bitcnt_q <= 3'h0;
        end else if (!busy || !enable) begin
            sck_q    <= 1'b0;
            bitcnt_q <= 3'h0;
        end else if (run) begin
            if (master && tick) begin
                sck_q <= !sck_q;
            end
            if (trail) begin
                bitcnt_q <= bitcnt_q + 3'h1;
            end
        end
    end

    // Shift register: load, sample, shift
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_q   <= 8'h00;
            sampled_q <= 1'b0;
        end else if (data_wr && !buffer_mode_enable) begin
            // Direct load; an early write corrupts the byte
            shift_q <= avs_writedata[7:0];
        end else if (start && buffer_mode_enable && txfull_q) begin
            shift_q <= txbuf_q;
        end else if (run && busy) begin
            if (lead) begin
                sampled_q <= in_bit;
            end
            if (trail) begin
                shift_q <= shift_nx;
            end
        end
    end

    // Transmit buffer (buffer mode only)
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txbuf_q  <= 8'h00;
            txfull_q <= 1'b0;
        end else if (data_wr && buffer_mode_enable) begin
            txbuf_q  <= avs_writedata[7:0];
            txfull_q <= 1'b1;
        end else if (start && buffer_mode_enable) begin
            txfull_q <= 1'b0;
        end
    end

    // Receive buffers: completed byte enters rx1, rx1 ages into rx2
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx1_q    <= 8'h00;
            rx2_q    <= 8'h00;
            rx2_ok_q <= 1'b0;
        end else if (finish) begin
            rx1_q <= shift_nx;
            if (!rx2_ok_q || data_rd) begin
                rx2_q    <= rx2_ok_q ? rx1_q : shift_nx;
                rx2_ok_q <= buffer_mode_enable;
            end
        end else if (data_rd && buffer_mode_enable) begin
            rx2_q    <= rx1_q;
            rx2_ok_q <= 1'b0;
        end
    end

    // ----------------
    // Flags: hardware set wins over a write-one clear
    // ----------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            wcol_q <= 1'b0;
        end else begin
            if (finish || mode_loss) begin
                done_q <= 1'b1;
            end else if (stat_wr
                         && avs_writedata[smsu_pkg::STAT_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (data_wr && busy && !buffer_mode_enable) begin
                wcol_q <= 1'b1;
            end else if (stat_wr
                         && avs_writedata[smsu_pkg::STAT_WCOL_BIT]) begin
                wcol_q <= 1'b0;
            end
        end
    end

    assign irq = done_q;

    // ----------------
    // Pin drive: overrides only while enabled
    // ----------------
    // Inputs forced per mode; user pins follow the direction register;
    // when disabled everything falls back to port control
    assign mosi_o   = out_bit;
    assign mosi_oe  = enable && master && dir_q[smsu_pkg::DIR_MOSI_BIT];
    assign sck_o    = sck_q;
    assign sck_oe   = enable && master && dir_q[smsu_pkg::DIR_SCK_BIT];
    assign sel_n_o  = 1'b0;
    assign sel_n_oe = enable && master && dir_q[smsu_pkg::DIR_SEL_BIT];
    assign miso_o   = out_bit;
    assign miso_oe  = enable && !master
                      && dir_q[smsu_pkg::DIR_MISO_BIT] && !s_lvl;

endmodule

`default_nettype wire

// ==== smsu_checker.sv ====
/* Port assertions for smsu_top.
 * Assumes it is bound into smsu_top; port names match. */
`timescale 1ns/1ns
`default_nettype none
module smsu_checker (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        dbg_halt,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        mosi_oe,
    input wire logic        miso_oe,
    input wire logic        sck_o,
    input wire logic        sck_oe,
    input wire logic        sel_n_i,
    input wire logic        sel_n_oe,
    input wire logic        irq
);
    // Enable shadow: pin rules only hold while enabled
    logic en_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                     && avs_address == smsu_pkg::CTRL_OFS) begin
            en_q <= avs_writedata[smsu_pkg::CTRL_ENABLE_BIT];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("request taken in its first cycle");
    property p_wait_next;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_next: assert property (p_wait_next)
        else $error("request not answered after one cycle");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
            |-> avs_readdata == smsu_pkg::BUS_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_mosi_miso;
        en_q && mosi_oe |-> !miso_oe;
    endproperty
    a_mosi_miso: assert property (p_mosi_miso)
        else $error("mosi and miso both driven");
    property p_sck_miso;
        en_q && sck_oe |-> !miso_oe;
    endproperty
    a_sck_miso: assert property (p_sck_miso)
        else $error("sck and miso both driven");
    property p_sel_miso;
        en_q && sel_n_oe |-> !miso_oe;
    endproperty
    a_sel_miso: assert property (p_sel_miso)
        else $error("select and miso both driven");
    property p_miso_sel;
        miso_oe |-> !sel_n_i || !$past(sel_n_i) || !$past(sel_n_i, 2)
            || !$past(sel_n_i, 3);
    endproperty
    a_miso_sel: assert property (p_miso_sel)
        else $error("miso driven while deselected");
    property p_halt;
        dbg_halt ##1 dbg_halt |-> $stable(sck_o);
    endproperty
    a_halt: assert property (p_halt)
        else $error("sck moved while halted");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_miso: cover property (miso_oe && !sel_n_i);
endmodule
bind smsu_top smsu_checker chk_u (.*);
`default_nettype wire

// ==== smsu_peer.sv ====
/* Mode 0 slave on the far side, MSB first.
 * Assumes select and tx byte come from the bench. */
`timescale 1ns/1ns
`default_nettype none
module smsu_peer (
    input wire logic       sck,
    input wire logic       mosi,
    input wire logic       sel_n,
    input wire logic [7:0] tx_byte,
    output logic           miso,
    output logic [7:0]     rx_byte
);
    logic [7:0] sh_q;  // Outgoing shifter
    // Load on select, then shift on the falling edge
    always @(negedge sel_n) sh_q = tx_byte;
    always @(negedge sck) if (!sel_n) sh_q <= {sh_q[6:0], 1'b0};
    always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
    // No pull on miso: deselected shows the inverse of the last bit
    assign miso = sel_n ? ~sh_q[7] : sh_q[7];
endmodule
`default_nettype wire

// ==== smsu_top_tb.sv ====
/* Self-checking bench for smsu_top with a slave model.
 * Assumes the package, the design and the checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module smsu_top_tb;
    logic        core_clk = 1'b0, rstn = 1'b0, dbg_halt = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, irq, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        sck_o, sck_oe, sel_n_o, sel_n_oe, peer_miso;
    logic        tb_mosi = 1'b0, tb_sck = 1'b0;
    logic        tb_sel_n = 1'b1, peer_sel_n = 1'b1;
    logic [7:0]  peer_tx = 8'h00, peer_rx;
    int          error_cnt = 0, checks = 0;
    // Pin levels resolved from the DUT's output enables
    wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic miso_w = miso_oe ? miso_o : peer_miso;
    wire logic sck_w = sck_oe ? sck_o : tb_sck;
    wire logic sel_w = sel_n_oe ? sel_n_o : tb_sel_n;
    always #2 core_clk = ~core_clk;
    smsu_top dut_u (.*, .mosi_i(mosi_w), .miso_i(miso_w), .sck_i(sck_w),
                    .sel_n_i(sel_w));
    smsu_peer peer_u (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n),
                      .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One Avalon cycle; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge core_clk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        if (i == 50) begin error_cnt++; give_verdict(); end
    endtask
    task automatic wait_irq;
        int n;
        for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge core_clk);
        if (n == 5000) begin error_cnt++; give_verdict(); end
    endtask
    // Master byte; halted a while at code 2, high time counted
    task automatic t_master(input logic [2:0] p, input logic dbl,
                            input logic lsb);
        logic [31:0] q;
        logic [7:0]  d, rd, rn;
        int          hi, i;
        d = {p, dbl, lsb, 3'h5};
        rd = {<<{d}};
        rn = ~rd;
        peer_tx <= ~d;
        bus(1'b1, smsu_pkg::CTRL_OFS, {21'h0, p, 4'h2, dbl, lsb, 2'h3}, q);
        peer_sel_n <= 1'b0;
        bus(1'b1, smsu_pkg::DATA_OFS, {24'h0, d}, q);
        chk({mosi_oe, sck_oe, miso_oe}, 3'h6);
        hi = 0;
        for (i = 0; i < 5000 && irq !== 1'b1; i++) begin
            @(posedge core_clk);
            dbg_halt <= (p == 3'h2 && i > 20 && i < 40);
            if (sck_o === 1'b1 && !dbg_halt) hi++;
        end
        if (i == 5000) begin error_cnt++; give_verdict(); end
        chk(hi, 8 * (dbl ? 1 : 2 << p));
        peer_sel_n <= 1'b1;
        chk(peer_rx, lsb ? rd : d);
        bus(1'b0, smsu_pkg::DATA_OFS, 32'h0, q);
        chk(q, {24'h0, lsb ? rn : ~d});
        bus(1'b1, smsu_pkg::STATUS_OFS, 32'h1, q);
        @(negedge core_clk);
        chk(irq, 1'b0);
        $display("master test code %0d ended", p);
    endtask
    // Early write collides; buffer mode takes a second byte
    task automatic t_wcol;
        logic [31:0] q;
        int          n;
        bus(1'b1, smsu_pkg::CTRL_OFS, 32'h23, q);
        bus(1'b1, smsu_pkg::DATA_OFS, 32'h11, q);
        bus(1'b1, smsu_pkg::DATA_OFS, 32'h22, q);
        wait_irq();
        bus(1'b0, smsu_pkg::STATUS_OFS, 32'h0, q);
        chk(q[1:0], 2'h3);
        bus(1'b1, smsu_pkg::STATUS_OFS, 32'h3, q);
        bus(1'b1, smsu_pkg::CTRL_OFS, 32'h33, q);
        bus(1'b1, smsu_pkg::DATA_OFS, 32'h33, q);
        bus(1'b1, smsu_pkg::DATA_OFS, 32'h44, q);
        wait_irq();
        bus(1'b0, smsu_pkg::STATUS_OFS, 32'h0, q);
        chk({q[3], q[1]}, 2'h2);
        for (n = 0; n < 40 && q[2] !== 1'b0; n++) begin
            bus(1'b0, smsu_pkg::STATUS_OFS, 32'h0, q);
        end
        chk(q[2], 1'b0);
        bus(1'b1, smsu_pkg::STATUS_OFS, 32'h3, q);
        $display("collision test ended");
    endtask
    // Select low drops the master to slave, then a slave byte
    task automatic t_slave;
        logic [31:0] q;
        logic [7:0]  r, m;
        int          b;
        m = 8'hc3;
        bus(1'b1, smsu_pkg::PINDIR_OFS, 32'h2, q);
        bus(1'b1, smsu_pkg::CTRL_OFS, 32'h3, q);
        tb_sel_n <= 1'b0;
        wait_irq();
        bus(1'b0, smsu_pkg::CTRL_OFS, 32'h0, q);
        chk(q[1], 1'b0);
        bus(1'b1, smsu_pkg::STATUS_OFS, 32'h1, q);
        bus(1'b1, smsu_pkg::DATA_OFS, 32'h5a, q);
        chk({mosi_oe, sck_oe, sel_n_oe, miso_oe}, 4'h1);
        for (b = 7; b >= 0; b--) begin
            @(posedge core_clk);
            tb_mosi <= m[b];
            repeat (4) @(posedge core_clk);
            r = {r[6:0], miso_w};
            tb_sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            tb_sck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        tb_sel_n <= 1'b1;
        wait_irq();
        bus(1'b0, smsu_pkg::DATA_OFS, 32'h0, q);
        chk(q, 32'hc3);
        chk(r, 8'h5a);
        $display("slave test ended");
    endtask
    initial begin
        logic [31:0] q;
        int          p;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus(1'b0, smsu_pkg::CTRL_OFS, 32'h0, q);
        chk(q, {21'h0, smsu_pkg::CTRL_RESET});
        bus(1'b0, smsu_pkg::PINDIR_OFS, 32'h0, q);
        chk(q, {28'h0, smsu_pkg::DIR_RESET});
        bus(1'b1, 4'h6, 32'hff, q);
        bus(1'b0, 4'h6, 32'h0, q);
        chk(q, smsu_pkg::BUS_UNMAPPED);
        bus(1'b1, smsu_pkg::PINDIR_OFS, 32'h5, q);
        for (p = 0; p < 7; p++) t_master(p[2:0], 1'b0, p[0]);
        t_master(3'h0, 1'b1, 1'b0);
        t_wcol();
        t_slave();
        give_verdict();
    end
endmodule
`default_nettype wire
